// >>> pbl_regs.svh
// Timing counts, widths and reset values for the pushbutton and LED logic
`ifndef PBL_REGS_SVH
`define PBL_REGS_SVH
`define PBL_CLK_HZ          20000000
`define PBL_TICK_US         1000
`define PBL_TICK_CYC        ((`PBL_CLK_HZ / 1000000) * `PBL_TICK_US)
`define PBL_CTL_DROP_MS     100
`define PBL_TEST_MIN_MS     250
`define PBL_STAGE1_MAX_MS   60000
`define PBL_STEP_MS         1000
`define PBL_NUM_USER        12
`define PBL_NUM_CTL         7
`define PBL_NUM_LED         48
`define PBL_NUM_LAMP        62
`define PBL_NUM_MINOR       8
`define PBL_NUM_MAJOR       8
`define PBL_LATCH_RESET     12'h000
`endif

// >>> pbl_pkg.sv
// Types shared by the pushbutton and LED logic
package pbl_pkg;
	typedef enum logic [1:0] {
		PBL_FN_DISABLED,
		PBL_FN_SELF_RESET,
		PBL_FN_LATCHED
	} pbl_fn_t;

	typedef struct packed {
		logic        press;
		logic        release_;
		logic [4:0]  key;
	} pbl_key_ev_t;
endpackage : pbl_pkg

// >>> pbl_tick_div.sv
// Divider that makes the one millisecond scan tick
`timescale 1ns/1ns
`default_nettype none
`include "pbl_regs.svh"
module pbl_tick_div #(
	parameter int CYCLES = `PBL_TICK_CYC
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Tick
	output logic      tick
);
	logic [15:0] count;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else if (count == 16'(CYCLES - 1)) begin
			count <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			tick  <= 1'b0;
		end
	end
endmodule : pbl_tick_div
`default_nettype wire

// >>> pbl_sync.sv
// Three-stage pin synchroniser; output changes when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pbl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i])
					dout[i] <= s3[i];
			end
		end
	end
endmodule : pbl_sync
`default_nettype wire

// >>> pbl_panel.sv
// Front-panel pushbutton, indicator and lamp test logic
`timescale 1ns/1ns
`default_nettype none
`include "pbl_regs.svh"
module pbl_panel
	import pbl_pkg::*;
#(
	parameter int NU        = `PBL_NUM_USER,
	parameter int NC        = `PBL_NUM_CTL,
	parameter int NL        = `PBL_NUM_LED,
	parameter int NMIN      = `PBL_NUM_MINOR,
	parameter int NMAJ      = `PBL_NUM_MAJOR,
	parameter int TICK_CYC  = `PBL_TICK_CYC,
	parameter int STAGE1_MS = `PBL_STAGE1_MAX_MS,
	parameter int STEP_MS   = `PBL_STEP_MS
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// Keys from the panel
	input  wire logic [NU-1:0]       user_key,
	input  wire logic [NC-1:0]       ctl_key,
	input  wire logic                reset_key,
	input  wire logic                large_option,
	// User key settings and non-volatile store
	input  wire logic [2*NU-1:0]     user_fn,
	input  wire logic                nv_valid,
	input  wire logic [NU-1:0]       nv_state,
	output logic      [NU-1:0]       nv_write_data,
	output logic                     nv_write,
	// User key operands and lamps
	output logic      [NU-1:0]       user_on,
	output logic      [NU-1:0]       user_off,
	output logic      [NU-1:0]       user_lamp,
	// Control keys
	input  wire logic                event_log_enable,
	output logic      [NC-1:0]       control_key_output,
	output logic                     ctl_event,
	output logic      [2:0]          ctl_event_key,
	// Indicators
	input  wire logic [NL-1:0]       led_operand,
	input  wire logic [NL-1:0]       indicator_latch_type,
	input  wire logic                remote_reset,
	input  wire logic                reset_operand,
	input  wire logic                trip_operand,
	input  wire logic                alarm_operand,
	output logic      [NL/2-1:0]     panel2_led,
	output logic      [NL/2-1:0]     panel3_led,
	output logic                     trip_led,
	output logic                     alarm_led,
	// Lamp test
	input  wire logic                lamp_test_enable,
	input  wire logic                lamp_test_trigger_source,
	output logic                     lamp_test_active,
	output logic                     lamp_test_started,
	// Self-test alarms
	input  wire logic [NMIN-1:0]     minor_raw,
	input  wire logic [NMIN-1:0]     minor_enable,
	input  wire logic [NMAJ-1:0]     major_raw,
	output logic      [NMIN-1:0]     minor_alarm,
	output logic      [NMAJ-1:0]     major_alarm,
	output logic                     any_minor,
	output logic                     any_self_test
);
	localparam int NK    = NU + NC + 1;
	localparam int DROPT = `PBL_CTL_DROP_MS;
	localparam int MINT  = `PBL_TEST_MIN_MS;

	typedef enum {LT_IDLE, LT_ALL_ON, LT_WALK_ON, LT_WALK_OFF} pbl_lt_t;

	logic          tick;
	logic [NK-1:0] keys_s;
	logic [NK-1:0] owned;
	logic [NK-1:0] owned_d;
	logic          any_owned;
	logic [NU-1:0] latch_st;
	logic          restored;
	logic [NL-1:0] led_hold;
	logic [NL-1:0] led_live;
	logic [6:0]    drop_cnt [NC];
	logic [NC-1:0] ctl_present;
	logic [NC-1:0] ctl_new;
	logic          trig_s;
	logic [8:0]    trig_cnt;
	logic          trig_q;
	logic          trig_q_d;
	logic          trig_rise;
	pbl_lt_t       lt_state;
	logic [15:0]   lt_ms;
	logic [5:0]    lt_idx;
	logic [NL-1:0] lamp_pattern;

	function automatic pbl_fn_t fn_of(input logic [2*NU-1:0] f, input int i);
		return pbl_fn_t'(f[2*i +: 2]);
	endfunction : fn_of

	pbl_tick_div #(.CYCLES(TICK_CYC)) u_tick (
		.clock (clock),
		.rst   (rst),
		.tick  (tick)
	);

	pbl_sync #(.W(NK + 1)) u_sync (
		.clock (clock),
		.rst   (rst),
		.din   ({lamp_test_trigger_source, reset_key, ctl_key, user_key}),
		.dout  ({trig_s, keys_s})
	);

	// A key is owned only when no other key is; held keys keep ownership
	assign any_owned = |owned;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			owned   <= '0;
			owned_d <= '0;
		end else begin
			owned_d <= owned;
			if (!any_owned) begin
				for (int k = 0; k < NK; k++) begin
					if (keys_s[k] && (owned == '0) && !(|(owned & ~owned))) begin
						if (!(|(keys_s & ((NK'(1) << k) - NK'(1)))))
							owned <= NK'(1) << k;
					end
				end
			end else if (!(|(owned & keys_s))) begin
				owned <= '0;
			end
		end
	end

	// Latched states: restored from storage once, saved on every change
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			latch_st      <= `PBL_LATCH_RESET;
			restored      <= 1'b0;
			nv_write      <= 1'b0;
			nv_write_data <= '0;
		end else begin
			nv_write <= 1'b0;
			if (!restored) begin
				if (nv_valid) begin
					latch_st <= nv_state;
					restored <= 1'b1;
				end
			end else begin
				for (int i = 0; i < NU; i++) begin
					if (fn_of(user_fn, i) == PBL_FN_LATCHED &&
					    owned[i] && !owned_d[i]) begin
						latch_st[i]      <= ~latch_st[i];
						nv_write_data[i] <= ~latch_st[i];
						nv_write         <= 1'b1;
					end else begin
						nv_write_data[i] <= latch_st[i];
					end
				end
			end
		end
	end

	generate
		for (genvar i = 0; i < NU; i++) begin : g_user
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					user_on[i]  <= 1'b0;
					user_off[i] <= 1'b0;
				end else begin
					case (fn_of(user_fn, i))
						PBL_FN_SELF_RESET: begin
							user_on[i]  <= owned[i];
							user_off[i] <= ~owned[i];
						end
						PBL_FN_LATCHED: begin
							user_on[i]  <= latch_st[i];
							user_off[i] <= ~latch_st[i];
						end
						default: begin
							user_on[i]  <= 1'b0;
							user_off[i] <= 1'b0;
						end
					endcase
				end
			end
			assign user_lamp[i] = user_on[i];
		end
	endgenerate

	// Control keys: keys 4 to 7 only exist with the large option
	assign ctl_present = large_option ? {NC{1'b1}} : NC'(7'h07);
	assign ctl_new = owned[NU +: NC] & ~owned_d[NU +: NC] & ctl_present;

	generate
		for (genvar c = 0; c < NC; c++) begin : g_ctl
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					drop_cnt[c]           <= 7'h00;
					control_key_output[c] <= 1'b0;
				end else if (owned[NU + c] && ctl_present[c]) begin
					drop_cnt[c]           <= 7'(DROPT);
					control_key_output[c] <= 1'b1;
				end else if (drop_cnt[c] != 7'h00) begin
					if (tick)
						drop_cnt[c] <= drop_cnt[c] - 7'h01;
				end else begin
					control_key_output[c] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl_event     <= 1'b0;
			ctl_event_key <= 3'h0;
		end else begin
			ctl_event <= event_log_enable && (|ctl_new);
			for (int c = 0; c < NC; c++) begin
				if (ctl_new[c])
					ctl_event_key <= 3'(c);
			end
		end
	end

	// Indicators keep tracking operands while the lamp test owns the lamps
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			led_hold <= '0;
		end else begin
			for (int j = 0; j < NL; j++) begin
				if (indicator_latch_type[j] && led_operand[j])
					led_hold[j] <= 1'b1;
				else if (!indicator_latch_type[j] ||
				         ((owned[NK-1] && !owned_d[NK-1] && !lamp_test_active) ||
				          remote_reset || reset_operand))
					led_hold[j] <= 1'b0;
			end
		end
	end
	assign led_live = led_operand | led_hold;

	// Trigger qualified by 250 ms of steady level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_cnt <= 9'h000;
			trig_q   <= 1'b0;
			trig_q_d <= 1'b0;
		end else begin
			trig_q_d <= trig_q;
			if (trig_s == trig_q) begin
				trig_cnt <= 9'h000;
			end else if (tick) begin
				if (trig_cnt == 9'(MINT - 1)) begin
					trig_q   <= trig_s;
					trig_cnt <= 9'h000;
				end else begin
					trig_cnt <= trig_cnt + 9'h001;
				end
			end
		end
	end
	assign trig_rise = trig_q && !trig_q_d;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lt_state          <= LT_IDLE;
			lt_ms             <= 16'h0000;
			lt_idx            <= 6'h00;
			lamp_test_started <= 1'b0;
		end else begin
			lamp_test_started <= 1'b0;
			if (tick)
				lt_ms <= lt_ms + 16'h0001;
			case (lt_state)
				LT_IDLE: begin
					if (lamp_test_enable && trig_rise) begin
						lt_state          <= LT_ALL_ON;
						lt_ms             <= 16'h0000;
						lamp_test_started <= 1'b1;
					end
				end
				LT_ALL_ON: begin
					if (lt_ms >= 16'(STAGE1_MS)) begin
						lt_state <= LT_IDLE;
					end else if (!trig_q) begin
						lt_state <= LT_WALK_ON;
						lt_ms    <= 16'h0000;
						lt_idx   <= 6'h00;
					end
				end
				LT_WALK_ON, LT_WALK_OFF: begin
					if (trig_rise) begin
						lt_state <= LT_IDLE;
					end else if (lt_ms >= 16'(STEP_MS)) begin
						lt_ms <= 16'h0000;
						if (lt_idx == 6'(NL - 1)) begin
							lt_idx   <= 6'h00;
							lt_state <= (lt_state == LT_WALK_ON) ?
							            LT_WALK_OFF : LT_IDLE;
						end else begin
							lt_idx <= lt_idx + 6'h01;
						end
					end
				end
				default: lt_state <= LT_IDLE;
			endcase
		end
	end
	assign lamp_test_active = (lt_state != LT_IDLE);

	// Index order is column-major, top to bottom within each column
	always_comb begin
		case (lt_state)
			LT_ALL_ON:   lamp_pattern = {NL{1'b1}};
			LT_WALK_ON:  lamp_pattern = NL'(1) << lt_idx;
			LT_WALK_OFF: lamp_pattern = ~(NL'(1) << lt_idx);
			default:     lamp_pattern = led_live;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			panel2_led <= '0;
			panel3_led <= '0;
			trip_led   <= 1'b0;
			alarm_led  <= 1'b0;
		end else begin
			panel2_led <= lamp_pattern[NL/2-1:0];
			panel3_led <= lamp_pattern[NL-1:NL/2];
			trip_led   <= lamp_test_active ? lamp_pattern[0] || lt_state == LT_ALL_ON
			                               : trip_operand;
			alarm_led  <= lamp_test_active ? lt_state != LT_WALK_ON
			                               : alarm_operand;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			minor_alarm   <= '0;
			major_alarm   <= '0;
			any_minor     <= 1'b0;
			any_self_test <= 1'b0;
		end else begin
			minor_alarm   <= minor_raw & minor_enable;
			major_alarm   <= major_raw;
			any_minor     <= |(minor_raw & minor_enable);
			any_self_test <= |(minor_raw & minor_enable) | (|major_raw);
		end
	end
endmodule : pbl_panel
`default_nettype wire

// >>> pbl_panel_props.sv
// Port assertions for the pushbutton and LED logic
`timescale 1ns/1ns
`default_nettype none
module pbl_panel_props #(
	parameter int TICK_CYC  = 20000,
	parameter int STAGE1_MS = 60000
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Inputs watched
	input wire logic [6:0]  ctl_key,
	input wire logic        event_log_enable,
	input wire logic [47:0] led_operand,
	input wire logic [47:0] indicator_latch_type,
	input wire logic        trip_operand,
	input wire logic [7:0]  minor_raw,
	input wire logic [7:0]  minor_enable,
	input wire logic [7:0]  major_raw,
	// Outputs judged
	input wire logic [11:0] user_on,
	input wire logic [11:0] user_off,
	input wire logic [11:0] user_lamp,
	input wire logic [6:0]  control_key_output,
	input wire logic        ctl_event,
	input wire logic [23:0] panel2_led,
	input wire logic [23:0] panel3_led,
	input wire logic        trip_led,
	input wire logic        lamp_test_active,
	input wire logic [7:0]  minor_alarm,
	input wire logic [7:0]  major_alarm,
	input wire logic        any_minor
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	int rel_cnt;
	int on_cnt;
	// Counts from the raw release, so the sync delay sits inside the margin
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rel_cnt <= 0;
		else
			rel_cnt <= ctl_key[0] ? 0 : rel_cnt + 1;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			on_cnt <= 0;
		else
			on_cnt <= (lamp_test_active && &{panel3_led, panel2_led}) ?
				on_cnt + 1 : 0;
	end
	property p_lamp;
		!lamp_test_active && !$past(lamp_test_active) |-> user_lamp == user_on;
	endproperty
	a_lamp: assert property (p_lamp) else $error("key lamp differs");
	property p_off;
		(user_on & user_off) == 12'h000;
	endproperty
	a_off: assert property (p_off) else $error("on and off both set");
	property p_led;
		!lamp_test_active && !$past(lamp_test_active) &&
		indicator_latch_type == 48'h0 && $stable(led_operand) |=>
		lamp_test_active || {panel3_led, panel2_led} == $past(led_operand);
	endproperty
	a_led: assert property (p_led) else $error("indicator bad");
	property p_trip;
		!lamp_test_active && $stable(trip_operand) |=>
		lamp_test_active || trip_led == $past(trip_operand);
	endproperty
	a_trip: assert property (p_trip) else $error("trip lamp bad");
	property p_minor;
		$stable(minor_raw) && $stable(minor_enable) |=>
		minor_alarm == ($past(minor_raw) & $past(minor_enable)) &&
		any_minor == |($past(minor_raw) & $past(minor_enable));
	endproperty
	a_minor: assert property (p_minor) else $error("minor alarm bad");
	property p_major;
		$stable(major_raw) |=> major_alarm == $past(major_raw);
	endproperty
	a_major: assert property (p_major) else $error("major alarm bad");
	property p_log;
		!event_log_enable && !$past(event_log_enable) |-> !ctl_event;
	endproperty
	a_log: assert property (p_log) else $error("event while off");
	property p_drop;
		$fell(control_key_output[0]) |->
		rel_cnt >= 99 * TICK_CYC && rel_cnt <= 101 * TICK_CYC + 8;
	endproperty
	a_drop: assert property (p_drop) else $error("dropout length");
	property p_stage1;
		on_cnt <= (STAGE1_MS + 2) * TICK_CYC;
	endproperty
	a_stage1: assert property (p_stage1) else $error("all-on too long");
endmodule : pbl_panel_props
bind pbl_panel pbl_panel_props #(.TICK_CYC(TICK_CYC), .STAGE1_MS(STAGE1_MS))
	pbl_panel_props_inst (.clock, .rst, .ctl_key, .event_log_enable,
	.led_operand, .indicator_latch_type, .trip_operand, .minor_raw,
	.minor_enable, .major_raw, .user_on, .user_off, .user_lamp,
	.control_key_output, .ctl_event, .panel2_led, .panel3_led, .trip_led,
	.lamp_test_active, .minor_alarm, .major_alarm, .any_minor);
`default_nettype wire

// >>> pbl_nv_model.sv
// Non-volatile store behind the latched key states
`timescale 1ns/1ns
`default_nettype none
module pbl_nv_model (
	// Clock
	input  wire logic        clock,
	// Store port
	input  wire logic        nv_write,
	input  wire logic [11:0] nv_write_data,
	output logic             nv_valid,
	output logic      [11:0] nv_state
);
	// No reset: contents must outlive a panel restart
	initial nv_state = 12'h000;
	initial nv_valid = 1'b0;
	always @(posedge clock) begin
		nv_valid <= 1'b1;
		if (nv_write)
			nv_state <= nv_write_data;
	end
endmodule : pbl_nv_model
`default_nettype wire

// >>> pbl_panel_bench.sv
// Self-checking bench for the pushbutton and LED logic
`timescale 1ns/1ns
`default_nettype none
module pbl_panel_bench
	import pbl_pkg::*;
;
	localparam int TC = 4;
	localparam int S1 = 400;
	localparam int ST = 20;
	logic        clock = 0, rst = 1, reset_key = 0, large_option = 0;
	logic        nv_valid, nv_write, event_log_enable = 0, ctl_event;
	logic        remote_reset = 0, reset_operand = 0, trip_operand = 0;
	logic        alarm_operand = 0, trip_led, alarm_led, lamp_test_active;
	logic        lamp_test_enable = 0, lamp_test_trigger_source = 0;
	logic        lamp_test_started, any_minor, any_self_test, seen;
	logic [11:0] user_key = 0, nv_state, nv_write_data;
	logic [11:0] user_on, user_off, user_lamp;
	logic [23:0] user_fn = 0, panel2_led, panel3_led;
	logic [6:0]  ctl_key = 0, control_key_output;
	logic [2:0]  ctl_event_key;
	logic [47:0] led_operand = 0, indicator_latch_type = 0;
	logic [7:0]  minor_raw = 0, minor_enable = 0, major_raw = 0;
	logic [7:0]  minor_alarm, major_alarm;
	logic [49:0] lamps;
	int          err_count = 0, checked = 0, cycles = 0, starts = 0;
	assign lamps = {trip_led, alarm_led, panel3_led, panel2_led};
	pbl_panel #(.TICK_CYC(TC), .STAGE1_MS(S1), .STEP_MS(ST)) pbl_panel_inst (
		.clock, .rst, .user_key, .ctl_key, .reset_key, .large_option,
		.user_fn, .nv_valid, .nv_state, .nv_write_data, .nv_write, .user_on,
		.user_off, .user_lamp, .event_log_enable, .control_key_output,
		.ctl_event, .ctl_event_key, .led_operand, .indicator_latch_type,
		.remote_reset, .reset_operand, .trip_operand, .alarm_operand,
		.panel2_led, .panel3_led, .trip_led, .alarm_led, .lamp_test_enable,
		.lamp_test_trigger_source, .lamp_test_active, .lamp_test_started,
		.minor_raw, .minor_enable, .major_raw, .minor_alarm, .major_alarm,
		.any_minor, .any_self_test);
	pbl_nv_model pbl_nv_model_inst (.clock, .nv_write, .nv_write_data,
		.nv_valid, .nv_state);
	always #25 clock = ~clock;
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask : cyc
	task automatic run(input int n);
		repeat (n) begin
			cyc(1);
			seen |= lamp_test_active;
			starts += (lamp_test_started === 1'b1);
		end
	endtask : run
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask : chk
	task automatic t_user;
		user_fn = {16'h0, PBL_FN_SELF_RESET, PBL_FN_DISABLED, PBL_FN_LATCHED,
			PBL_FN_SELF_RESET};
		user_key[0] = 1;
		cyc(8);
		chk({user_lamp[0], user_on[0], user_off[0]}, 3'b110);
		user_key[3] = 1;
		cyc(8);
		chk(user_on[3], 0);
		user_key = 0;
		cyc(8);
		chk({user_on[0], user_off[0]}, 2'b01);
		user_key[2] = 1;
		cyc(8);
		chk({user_on[2], user_off[2]}, 0);
		user_key[2] = 0;
		cyc(8);
		for (int i = 0; i < 3; i++) begin
			user_key[1] = 1;
			cyc(20);
			user_key[1] = 0;
			cyc(8);
			chk({user_lamp[1], user_on[1], user_off[1]}, i[0] ? 1 : 6);
		end
		rst = 1;
		cyc(12);
		rst = 0;
		cyc(10);
		chk(user_on[1:0], 2'b10);
	endtask : t_user
	task automatic t_ctl;
		int ev;
		ev = 0;
		event_log_enable = 1;
		ctl_key[0] = 1;
		repeat (20) begin
			cyc(1);
			ev += (ctl_event === 1'b1);
		end
		chk({ev, control_key_output[0]}, {32'd1, 1'b1});
		ctl_key[0] = 0;
		repeat (380) begin
			cyc(1);
			ev += (ctl_event === 1'b1);
		end
		chk({ev, control_key_output[0]}, {32'd1, 1'b1});
		cyc(40);
		chk(control_key_output[0], 0);
		event_log_enable = 0;
		for (int i = 0; i < 2; i++) begin
			large_option = i[0];
			ctl_key[4] = 1;
			repeat (20) begin
				cyc(1);
				ev += (ctl_event === 1'b1);
			end
			chk({ev, control_key_output[4]}, {32'd1, i[0]});
			chk(ctl_event_key, i[0] ? 3'h4 : 3'h0);
			ctl_key[4] = 0;
			cyc(450);
		end
	endtask : t_ctl
	task automatic t_led;
		led_operand = 48'h0001_0000_0008;
		cyc(3);
		chk({panel3_led, panel2_led}, led_operand);
		for (int k = 0; k < 3; k++) begin
			indicator_latch_type[32] = 1;
			cyc(3);
			led_operand = 0;
			cyc(3);
			chk({panel3_led[8], panel2_led[3]}, 2'b10);
			{reset_key, reset_operand, remote_reset} = 3'b001 << k;
			cyc(10);
			{reset_key, reset_operand, remote_reset} = 0;
			cyc(8);
			chk(panel3_led[8], 0);
			led_operand = 48'h0001_0000_0000;
		end
		led_operand = 0;
		indicator_latch_type = 0;
		trip_operand = 1;
		cyc(3);
		chk({trip_led, alarm_led}, 2'b10);
		{trip_operand, alarm_operand} = 2'b01;
		cyc(3);
		chk({trip_led, alarm_led}, 2'b01);
		alarm_operand = 0;
		minor_raw = 8'hff;
		minor_enable = 8'h5a;
		major_raw = 8'h81;
		cyc(3);
		chk({minor_alarm, major_alarm, any_self_test}, 17'h0b503);
		minor_enable = 0;
		major_raw = 8'h04;
		cyc(3);
		chk({any_minor, any_self_test, minor_alarm}, 10'h100);
		major_raw = 0;
	endtask : t_led
	task automatic t_lamp;
		int n;
		logic s2, s3;
		{n, s2, s3, seen} = 0;
		lamp_test_enable = 1;
		lamp_test_trigger_source = 1;
		run(200 * TC);
		lamp_test_trigger_source = 0;
		run(20);
		chk(seen, 0);
		lamp_test_trigger_source = 1;
		run((250 + S1 + 30) * TC);
		chk({seen, lamp_test_active}, 2'b10);
		lamp_test_trigger_source = 0;
		run(300 * TC);
		chk(lamp_test_active, 0);
		lamp_test_trigger_source = 1;
		run(300 * TC);
		chk(&lamps, 1);
		lamp_test_trigger_source = 0;
		run(300 * TC);
		chk({lamp_test_active, $countones(lamps) < 2}, 2'b11);
		lamp_test_trigger_source = 1;
		run(300 * TC);
		lamp_test_trigger_source = 0;
		run(300 * TC);
		chk({lamp_test_active, lamps}, 0);
		lamp_test_trigger_source = 1;
		run(300 * TC);
		lamp_test_trigger_source = 0;
		while (lamp_test_active === 1'b1 && n < (120 * ST + 400) * TC) begin
			cyc(1);
			n++;
			s2 |= ($countones(lamps) == 1);
			s3 |= ($countones(lamps) == 49);
		end
		chk({s2, s3, lamp_test_active}, 3'b110);
		chk(n >= 96 * ST * TC && n <= (96 * ST + 260) * TC, 1);
		chk(starts, 3);
	endtask : t_lamp
	task automatic wrap_up;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// Cut a hang short; the full run needs about 21000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		cyc(12);
		rst = 0;
		cyc(4);
		t_user();
		t_ctl();
		t_led();
		t_lamp();
		wrap_up();
	end
endmodule : pbl_panel_bench
`default_nettype wire
